// File: hdl/lfs_map.vh
// Constants for the LED driver fault supervisor.
// Assumes inclusion by bare name from the design file.
`ifndef LFS_MAP_VH
`define LFS_MAP_VH
// ============================================================
// Fault counting
`define LFS_OC_CYCLES 3'h4
`define LFS_ARM_PULSE 2'h2
// Gate-low cycles before the open-sense check may fire; longer than the
// input synchroniser so a sense level left over from the on time is gone.
`define LFS_OPEN_LOW 3'h6
// ============================================================
// Synchronised input vector bit positions
`define LFS_IN_OCF 0
`define LFS_IN_OCD 1
`define LFS_IN_PKF 2
`define LFS_IN_PKD 3
`define LFS_IN_OV 4
`define LFS_IN_UV 5
`define LFS_IN_OT 6
`define LFS_IN_STRAP 7
`define LFS_IN_EN 8
`endif

// File: hdl/lfs_supervisor.v
// Fault supervisor for a step-down LED driver: gates the switch drive.
// Assumes analog comparators give level flags asynchronous to ref_clk_i,
// and that the switching controller supplies its gate request.
//
// Overview of operation
// R1 - Over-temperature flag forces gate low and stops switching.
// R2 - Thermal shutdown clears by itself when the flag drops.
// R3 - Over-current fault after four consecutive high cycles; low cycle restarts.
// R4 - Over-current counting skips first pulse after power-on, starts at second.
// R5 - Over-current fault forces gate low and latches until reset or toggle.
// R6 - Supply-low flag forces gate low and enters standby.
// R7 - Supply-low lockout releases automatically when the flag drops.
// R8 - Supply-high detection armed only from second switching pulse.
// R9 - Supply-high fault forces gate low and latches until reset or toggle.
// R10 - Sense at peak while gate low latches sense-open fault.
// R11 - Switching resumes only when every active fault has cleared.
// R12 - Regulator-strapped dim input selects fixed thresholds.
// R13 - Other party clears latches by power cycle or enable toggle.
// R14 - Flags synchronised; cycle is one gate pulse; toggle is low then rise.
`include "lfs_map.vh"
module lfs_supervisor (
  input wire ref_clk_i,
  input wire nrst_i,
  input wire enable_i,
  input wire gate_req_i,
  input wire peak_dim_strap_i,
  input wire over_temp_i,
  input wire supply_low_i,
  input wire supply_high_i,
  input wire oc_fixed_i,
  input wire oc_dim_i,
  input wire peak_fixed_i,
  input wire peak_dim_i,
  output reg gate_o,
  output wire standby_o,
  output wire switching_stop_o,
  output wire over_temperature_shutdown_o,
  output wire over_current_fault_o,
  output wire supply_low_lockout_o,
  output wire supply_high_fault_o,
  output wire sense_open_fault_o
);
  // ==========================================================
  // Shared helpers

  // Saturating three-bit increment, used by both cycle counters.
  function [2:0] sat_inc;
    input [2:0] value;
    input [2:0] limit;
    begin
      if (value == limit)
        sat_inc = value;
      else
        sat_inc = value + 3'h1;
    end
  endfunction

  // Threshold selection: a strapped dim input means the fixed comparator.
  function pick;
    input strapped;
    input fixed_lvl;
    input dim_lvl;
    begin
      if (strapped)
        pick = fixed_lvl;
      else
        pick = dim_lvl;
    end
  endfunction

  // ==========================================================
  // Input synchronisers
  // Every flag, strap and enable pin passes three flops; a level counts only once the second and
  // third stages agree, so one metastable sample never reaches the logic.
  // All comparator outputs share one vector so they see equal latency.
  localparam N = 9;
  reg [N-1:0] s1;
  reg [N-1:0] s2;
  reg [N-1:0] s3;
  reg [N-1:0] flt;
  wire [N-1:0] raw;
  wire [N-1:0] agree;
  wire [N-1:0] next_flt;
  assign raw = {enable_i, peak_dim_strap_i, over_temp_i, supply_low_i,
    supply_high_i, peak_dim_i, peak_fixed_i, oc_dim_i, oc_fixed_i};
  assign agree = ~(s2 ^ s3);
  assign next_flt = (agree & s3) | (~agree & flt);
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      s1 <= {N{1'b0}};
      s2 <= {N{1'b0}};
      s3 <= {N{1'b0}};
      flt <= {N{1'b0}};
    end else begin
      s1 <= raw; // R14
      s2 <= s1;
      s3 <= s2;
      flt <= next_flt; // R14
    end
  end

  // Filtered levels.
  wire en_s = flt[`LFS_IN_EN];
  wire strap = flt[`LFS_IN_STRAP];
  wire ot_s = flt[`LFS_IN_OT];
  wire uv_s = flt[`LFS_IN_UV];
  wire ov_s = flt[`LFS_IN_OV];
  wire oc_s = pick(strap, flt[`LFS_IN_OCF], flt[`LFS_IN_OCD]); // R12
  wire pk_f = pick(strap, flt[`LFS_IN_PKF], flt[`LFS_IN_PKD]); // R12

  // ==========================================================
  // Switching pulse tracking
  // Only gate turn-on edges count; the count stops once detection is armed,
  // so it never wraps and disarms over a long run.
  reg gate_q;
  reg [1:0] pulses;
  reg [1:0] next_pulses;
  wire rise = gate_o & ~gate_q; // R14
  wire fall = ~gate_o & gate_q;
  wire armed = (pulses == `LFS_ARM_PULSE); // R4 R8
  always @* begin
    next_pulses = pulses;
    if (rise && !armed)
      next_pulses = pulses + 2'h1;
  end
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      gate_q <= 1'b0;
      pulses <= 2'h0;
    end else begin
      gate_q <= gate_o;
      pulses <= next_pulses;
    end
  end

  // ==========================================================
  // Enable toggle detection
  // A rise only counts after a filtered low was seen, so a steady high never clears
  // anything; the first rise out of reset counts, as the filter reads low until filled.
  reg en_q;
  reg en_seen_low;
  reg next_en_seen_low;
  wire en_rise = en_s & ~en_q & en_seen_low; // R14 R13
  always @* begin
    next_en_seen_low = en_seen_low;
    if (!en_s)
      next_en_seen_low = 1'b1;
    else if (en_rise)
      next_en_seen_low = 1'b0;
  end
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      en_q <= 1'b0;
      en_seen_low <= 1'b0;
    end else begin
      en_q <= en_s;
      en_seen_low <= next_en_seen_low;
    end
  end

  // ==========================================================
  // Over-current cycle counter
  // A cycle is a hit if sense reached the threshold at any time while the
  // gate was on; the synchroniser lag is covered by also taking the level
  // seen at the falling edge.
  reg oc_hit;
  reg next_oc_hit;
  reg [2:0] oc_cnt;
  reg [2:0] next_oc_cnt;
  wire oc_cycle_hit = oc_hit | oc_s;
  wire oc_trip = fall & armed & oc_cycle_hit &
    (oc_cnt == `LFS_OC_CYCLES - 3'h1); // R3
  always @* begin
    next_oc_hit = oc_hit;
    if (rise)
      next_oc_hit = 1'b0;
    else if (gate_o && oc_s)
      next_oc_hit = 1'b1;
  end
  always @* begin
    next_oc_cnt = oc_cnt;
    if (en_rise)
      next_oc_cnt = 3'h0;
    else if (fall && armed) begin
      if (oc_cycle_hit)
        next_oc_cnt = sat_inc(oc_cnt, `LFS_OC_CYCLES); // R3
      else
        next_oc_cnt = 3'h0; // R3
    end
  end
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      oc_hit <= 1'b0;
      oc_cnt <= 3'h0;
    end else begin
      oc_hit <= next_oc_hit;
      oc_cnt <= next_oc_cnt;
    end
  end

  // ==========================================================
  // Gate-low timer for the open-sense check
  // Sense still shows the on-time current for a few cycles after turn-off,
  // so the check waits until that level has left the synchroniser.
  reg [2:0] low_cnt;
  reg [2:0] next_low_cnt;
  wire open_seen = (low_cnt == `LFS_OPEN_LOW) & pk_f; // R10
  always @* begin
    next_low_cnt = 3'h0;
    if (!gate_o)
      next_low_cnt = sat_inc(low_cnt, `LFS_OPEN_LOW);
  end
  always @(posedge ref_clk_i) begin
    if (!nrst_i)
      low_cnt <= 3'h0;
    else
      low_cnt <= next_low_cnt;
  end

  // ==========================================================
  // Fault latches
  // A fresh fault wins over an enable toggle in the same cycle, so a supply-high or
  // sense-open fault still present survives a toggle; an over-current latch clears and recounts.
  reg oc_lat;
  reg ov_lat;
  reg so_lat;
  reg next_oc_lat;
  reg next_ov_lat;
  reg next_so_lat;
  always @* begin
    next_oc_lat = oc_lat;
    next_ov_lat = ov_lat;
    next_so_lat = so_lat;
    if (oc_trip)
      next_oc_lat = 1'b1; // R5
    else if (en_rise)
      next_oc_lat = 1'b0; // R13
    if (armed && ov_s)
      next_ov_lat = 1'b1; // R9
    else if (en_rise)
      next_ov_lat = 1'b0;
    if (open_seen)
      next_so_lat = 1'b1; // R10
    else if (en_rise)
      next_so_lat = 1'b0;
  end
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      oc_lat <= 1'b0;
      ov_lat <= 1'b0;
      so_lat <= 1'b0;
    end else begin
      oc_lat <= next_oc_lat;
      ov_lat <= next_ov_lat;
      so_lat <= next_so_lat;
    end
  end

  // ==========================================================
  // Gate drive
  wire run_ok;
  assign run_ok = ~ot_s & ~uv_s & ~oc_lat & ~ov_lat & ~so_lat & en_s; // R11
  always @(posedge ref_clk_i) begin
    if (!nrst_i)
      gate_o <= 1'b0;
    else
      gate_o <= gate_req_i & run_ok; // R1 R2 R6 R7
  end

  // ==========================================================
  // Status outputs
  assign standby_o = uv_s | ~en_s; // R6
  assign switching_stop_o = ot_s | oc_lat | ov_lat | so_lat;
  assign over_temperature_shutdown_o = ot_s; // R1
  assign over_current_fault_o = oc_lat;
  assign supply_low_lockout_o = uv_s; // R7
  assign supply_high_fault_o = ov_lat;
  assign sense_open_fault_o = so_lat;
endmodule

// File: sim/lfs_sense.sv
// Sense comparators and switch stage beside the supervisor.
// Assumes gate_i is the supervisor gate drive.
module lfs_sense (
  input wire gate_i,
  input wire fix_i,
  input wire short_i,
  input wire open_i,
  output wire oc_fixed_o,
  output wire oc_dim_o,
  output wire peak_fixed_o,
  output wire peak_dim_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // A shorted load trips only while on; an open pin floats high always.
  wire hit = open_i | (short_i & gate_i);
  assign oc_fixed_o = hit & fix_i;
  assign oc_dim_o = hit & ~fix_i;
  assign peak_fixed_o = hit & fix_i;
  assign peak_dim_o = hit & ~fix_i;
endmodule

// File: sim/lfs_supervisor_monitor.sv
// Port checker for the fault supervisor.
// Assumes binding onto lfs_supervisor.
module lfs_supervisor_monitor (
  input wire ref_clk_i,
  input wire nrst_i,
  input wire enable_i,
  input wire over_temp_i,
  input wire supply_low_i,
  input wire gate_o,
  input wire standby_o,
  input wire switching_stop_o,
  input wire over_temperature_shutdown_o,
  input wire over_current_fault_o,
  input wire supply_high_fault_o,
  input wire sense_open_fault_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  // Eight cycles outlast the input synchroniser.
  sequence s_en_on; enable_i[*8]; endsequence
  a_stop_gate: assert property (switching_stop_o |=> !gate_o)
    else $error("gate on in stop");
  a_idle_gate: assert property (standby_o |=> !gate_o)
    else $error("gate on in standby");
  a_heat_stop: assert property (over_temp_i[*8] |-> switching_stop_o)
    else $error("no thermal stop");
  a_heat_clear: assert property
    ((!over_temp_i)[*8] |-> !over_temperature_shutdown_o) else $error("hot");
  a_low_idle: assert property (supply_low_i[*8] |-> standby_o)
    else $error("no standby");
  a_low_clear: assert property
    ((enable_i && !supply_low_i)[*8] |-> !standby_o) else $error("stuck");
  a_oc_hold: assert property
    (s_en_on ##0 over_current_fault_o |=> over_current_fault_o)
    else $error("latch lost");
  a_latch_stop: assert property
    (over_current_fault_o | supply_high_fault_o | sense_open_fault_o
      |-> switching_stop_o) else $error("latch without stop");
endmodule
bind lfs_supervisor lfs_supervisor_monitor mon (.*);

// File: sim/lfs_supervisor_test.sv
// Self-checking bench for the fault supervisor.
// Assumes lfs_sense as the far side and a 10 MHz clock.
module lfs_supervisor_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 0, nrst_i = 0, enable_i = 1, gate_req_i = 0, seen = 0;
  logic peak_dim_strap_i = 1, over_temp_i = 0, supply_low_i = 0;
  logic supply_high_i = 0, fix = 1, shorted = 0, opened = 0;
  wire oc_fixed_i, oc_dim_i, peak_fixed_i, peak_dim_i, gate_o, standby_o;
  wire switching_stop_o, over_temperature_shutdown_o, over_current_fault_o;
  wire supply_low_lockout_o, supply_high_fault_o, sense_open_fault_o;
  int error_cnt = 0, comparisons = 0;
  lfs_supervisor dut (.*);
  lfs_sense far (.gate_i(gate_o), .fix_i(fix), .short_i(shorted),
    .open_i(opened), .oc_fixed_o(oc_fixed_i), .oc_dim_o(oc_dim_i),
    .peak_fixed_o(peak_fixed_i), .peak_dim_o(peak_dim_i));
  initial forever #50 ref_clk_i = ~ref_clk_i;
  task tick(int n);
    repeat (n) @(negedge ref_clk_i) seen |= gate_o;
  endtask
  task pulse(int n);
    repeat (n) begin
      gate_req_i = 1;
      tick(8);
      gate_req_i = 0;
      tick(8);
    end
  endtask
  task chk(logic got, logic exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task power;
    nrst_i = 0;
    tick(8);
    nrst_i = 1;
    tick(2);
  endtask
  task toggle;
    enable_i = 0;
    tick(8);
    enable_i = 1;
    tick(8);
  endtask
  task report_and_stop;
    if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    report_and_stop;
  end
  initial begin
    power();
    shorted = 1;
    pulse(4);
    chk(over_current_fault_o, 0);
    pulse(1);
    chk(over_current_fault_o, 1);
    power();
    chk(over_current_fault_o, 0);
    shorted = 0;
    supply_high_i = 1;
    tick(10);
    chk(supply_high_fault_o, 0);
    pulse(2);
    chk(supply_high_fault_o, 1);
    supply_high_i = 0;
    toggle();
    chk(supply_high_fault_o, 0);
    fix = 0;
    shorted = 1;
    pulse(5);
    chk(over_current_fault_o, 0);
    peak_dim_strap_i = 0;
    pulse(3);
    shorted = 0;
    pulse(1);
    shorted = 1;
    pulse(3);
    chk(over_current_fault_o, 0);
    pulse(1);
    chk(over_current_fault_o, 1);
    shorted = 0;
    toggle();
    chk(over_current_fault_o, 0);
    opened = 1;
    tick(12);
    opened = 0;
    tick(10);
    chk(sense_open_fault_o, 1);
    toggle();
    chk(sense_open_fault_o, 0);
    over_temp_i = 1;
    supply_low_i = 1;
    tick(10);
    chk(supply_low_lockout_o, 1);
    chk(standby_o, 1);
    chk(switching_stop_o, 1);
    chk(over_temperature_shutdown_o, 1);
    over_temp_i = 0;
    tick(10);
    chk(over_temperature_shutdown_o, 0);
    seen = 0;
    pulse(1);
    chk(seen, 0);
    supply_low_i = 0;
    tick(10);
    seen = 0;
    pulse(1);
    chk(seen, 1);
    report_and_stop;
  end
endmodule
